/* File: hdl/vpdma_defs.vh */
// Constants for the video port DMA sizing and addressing block.
// Assumes a 12-bit APB byte address and 32-bit data words.
// Summary of operation
// - A 9-bit request size field sets each DMA transfer size; bits above it read as zero.
// - Each channel owns its own 64-bit by 64-word ping-pong buffer.
// - In capture, a request is raised once stored bytes reach the request size.
// - In output, a request is raised once bytes sent out reach the request size.
// - In sub-picture mode the source start is the first active pixel after SAV in the first line.
// - Horizontal sub-picture sizes of 10h, 20h, 40h, 80h and 100h bytes are accepted.
// - In raster mode the area start maps to the first active pixel after SAV in the first line.
// - For VBI data the area start maps to just after SAV in the first blanking line.
// - Channel 1 top luma start is used only in Y/C multiplexed format, else ignored.
// - Raster and raw capture write the field from the top luma start address.
`ifndef VPDMA_DEFS_VH
`define VPDMA_DEFS_VH

// ==========================================
// Register map (byte addresses)
`define VPDMA_OFF_REQSZ 12'h000
`define VPDMA_OFF_CH0TY 12'h004
`define VPDMA_OFF_CH1TY 12'h008
`define VPDMA_OFF_CTRL 12'h00C
`define VPDMA_OFF_HSZ 12'h010
`define VPDMA_OFF_STAT 12'h014

// ==========================================
// Field layout
`define VPDMA_REQSZ_W 9
`define VPDMA_CTRL_W 7
`define VPDMA_CTRL_CAP0 0
`define VPDMA_CTRL_CAP1 1
`define VPDMA_CTRL_MODE0 3:2
`define VPDMA_CTRL_MODE1 5:4
`define VPDMA_CTRL_YCMUX 6
`define VPDMA_HSZ0 8:0
`define VPDMA_HSZ1 24:16

// ==========================================
// Reset values and encodings
`define VPDMA_RST_REQSZ 9'h020
`define VPDMA_RST_ADDR 32'h00000000
`define VPDMA_RST_CTRL 7'h00
`define VPDMA_RST_HSZ 9'h010
`define VPDMA_MODE_RASTER 2'h0
`define VPDMA_MODE_SUBPIC 2'h1
`define VPDMA_MODE_RAW 2'h2
`define VPDMA_RASTER_MASK 32'hFFFFFFF8
`define VPDMA_WORD_BYTES 10'h008
`define VPDMA_CNT_W 10

`endif

/* File: hdl/vpdma_chan.v */
// One channel's ping-pong buffer and request bookkeeping.
// Assumes strobes from logic on clk; strobes while not ready are dropped.
`timescale 1ns/1ns
`include "vpdma_defs.vh"
module vpdma_chan #(
  parameter DW = 64,
  parameter AW = 6
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Configuration
  input wire capMode,
  input wire [`VPDMA_REQSZ_W-1:0] reqSize,
  // Video side
  input wire vidStb,
  input wire [DW-1:0] vidWrData,
  output wire vidReady,
  // Memory side
  input wire memStb,
  input wire [DW-1:0] memWrData,
  output wire memReady,
  input wire dmaAck,
  output wire dmaReq,
  // Shared read data and status
  output reg [DW-1:0] rdData_q,
  output reg [`VPDMA_CNT_W-1:0] bytes_q
);
  localparam [AW:0] DEPTH = 1 << AW;
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire full = (cnt_q == DEPTH);
  wire empty = (cnt_q == {(AW+1){1'b0}});
  wire wrStb = capMode ? vidStb : memStb;
  wire rdStb = capMode ? memStb : vidStb;
  wire wrEn = wrStb & ~full;
  wire rdEn = rdStb & ~empty;
  wire [DW-1:0] wrData = capMode ? vidWrData : memWrData;
  wire vidMove = capMode ? wrEn : rdEn;
  wire [`VPDMA_CNT_W-1:0] reqBytes = {1'b0, reqSize};

  // Ready is a plain function of the fill level
  assign vidReady = capMode ? ~full : ~empty;
  assign memReady = capMode ? ~empty : ~full;
  assign dmaReq = (reqSize != {`VPDMA_REQSZ_W{1'b0}}) && (bytes_q >= reqBytes);

  // Storage write has no reset; contents are don't-care until written
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wp_q] <= wrData;
    end
  end

  // Pointers, level and read register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      rdData_q <= {DW{1'b0}};
    end else begin
      if (wrEn) wp_q <= wp_q + 1'b1;
      if (rdEn) begin
        rp_q <= rp_q + 1'b1;
        rdData_q <= mem[rp_q];
      end
      if (wrEn && !rdEn) cnt_q <= cnt_q + 1'b1;
      else if (rdEn && !wrEn) cnt_q <= cnt_q - 1'b1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bytes_q <= {`VPDMA_CNT_W{1'b0}};
    end else begin
      // Ack and new data may coincide; both are applied
      bytes_q <= bytes_q + (vidMove ? `VPDMA_WORD_BYTES : {`VPDMA_CNT_W{1'b0}})
                 - ((dmaAck && dmaReq) ? reqBytes : {`VPDMA_CNT_W{1'b0}});
    end
  end
endmodule // vpdma_chan

/* File: hdl/vpdma_addr.v */
// SDRAM address generator for one channel's top luma area.
// Assumes one-cycle start strobes already synchronised to clk.
`timescale 1ns/1ns
`include "vpdma_defs.vh"
module vpdma_addr (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Configuration
  input wire enable,
  input wire [1:0] mode,
  input wire [31:0] base,
  input wire [`VPDMA_REQSZ_W-1:0] hsize,
  input wire [`VPDMA_REQSZ_W-1:0] reqSize,
  // Events
  input wire actStart,
  input wire vbiStart,
  input wire dmaAck,
  // Address out
  output reg [31:0] addr_q
);
  reg [31:0] start;
  // mask from the power-of-two sub-picture width
  wire [31:0] spMask = ~({23'h000000, hsize} - 32'h00000001);

  // Start aligned in raster and sub-picture modes, forgiving low bits software should have cleared
  always @* begin
    start = base;
    if (mode == `VPDMA_MODE_SUBPIC) begin
      start = base & spMask;
    end else if (mode == `VPDMA_MODE_RASTER) begin
      start = base & `VPDMA_RASTER_MASK;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= `VPDMA_RST_ADDR;
    end else if (!enable) begin
      addr_q <= `VPDMA_RST_ADDR;
    end else if (vbiStart) begin
      addr_q <= start;
    end else if (actStart) begin
      addr_q <= start;
    end else if (dmaAck) begin
      addr_q <= addr_q + {23'h000000, reqSize};
    end
  end
endmodule // vpdma_addr

/* File: hdl/vpdma_top.v */
// Video port DMA sizing and addressing, two channels, APB slave.
// Assumes timing pins are asynchronous; video and SDRAM strobes are on clk.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "vpdma_defs.vh"
module vpdma_top #(
  parameter DW = 64,
  parameter AW = 6
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Timing pins, level high during the marked line start
  input wire ch0ActivePin,
  input wire ch0VbiPin,
  input wire ch1ActivePin,
  input wire ch1VbiPin,
  // Channel 0 video side
  input wire ch0VidStb,
  input wire [DW-1:0] ch0VidWrData,
  output wire [DW-1:0] ch0VidRdData,
  output wire ch0VidReady,
  // Channel 0 SDRAM side
  input wire ch0MemStb,
  input wire [DW-1:0] ch0MemWrData,
  output wire [DW-1:0] ch0MemRdData,
  output wire ch0MemReady,
  output wire ch0DmaReq,
  input wire ch0DmaAck,
  output wire [31:0] ch0DmaAddr,
  // Channel 1 video side
  input wire ch1VidStb,
  input wire [DW-1:0] ch1VidWrData,
  output wire [DW-1:0] ch1VidRdData,
  output wire ch1VidReady,
  // Channel 1 SDRAM side
  input wire ch1MemStb,
  input wire [DW-1:0] ch1MemWrData,
  output wire [DW-1:0] ch1MemRdData,
  output wire ch1MemReady,
  output wire ch1DmaReq,
  input wire ch1DmaAck,
  output wire [31:0] ch1DmaAddr
);

  // ==========================================
  // Registers
  reg [`VPDMA_REQSZ_W-1:0] reqSize_q;
  reg [31:0] ch0TopLuma_q;
  reg [31:0] ch1TopLuma_q;
  reg [`VPDMA_CTRL_W-1:0] ctrl_q;
  reg [`VPDMA_REQSZ_W-1:0] hsize0_q;
  reg [`VPDMA_REQSZ_W-1:0] hsize1_q;

  wire [DW-1:0] ch0RdData;
  wire [DW-1:0] ch1RdData;
  wire [`VPDMA_CNT_W-1:0] ch0Bytes;
  wire [`VPDMA_CNT_W-1:0] ch1Bytes;

  wire ycMux = ctrl_q[`VPDMA_CTRL_YCMUX];
  wire cap0 = ctrl_q[`VPDMA_CTRL_CAP0];
  wire cap1 = ctrl_q[`VPDMA_CTRL_CAP1];

  // ==========================================
  // APB slave
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  wire wrAcc = psel & penable & pwrite;
  wire rdAcc = psel & penable & ~pwrite;

  // Byte-lane merge of write data into a 32-bit old value
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] strb;
    integer i;
    begin
      laneMerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) laneMerge[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
  endfunction

  wire [31:0] reqMerge = laneMerge({23'h000000, reqSize_q}, pwdata, pstrb);
  wire [31:0] ch0Merge = laneMerge(ch0TopLuma_q, pwdata, pstrb);
  wire [31:0] ch1Merge = laneMerge(ch1TopLuma_q, pwdata, pstrb);
  wire [31:0] ctrlMerge = laneMerge({25'h0000000, ctrl_q}, pwdata, pstrb);
  wire [31:0] hszOld = {7'h00, hsize1_q, 7'h00, hsize0_q};
  wire [31:0] hszMerge = laneMerge(hszOld, pwdata, pstrb);

  // Register writes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reqSize_q <= `VPDMA_RST_REQSZ;
      ch0TopLuma_q <= `VPDMA_RST_ADDR;
      ch1TopLuma_q <= `VPDMA_RST_ADDR;
      ctrl_q <= `VPDMA_RST_CTRL;
      hsize0_q <= `VPDMA_RST_HSZ;
      hsize1_q <= `VPDMA_RST_HSZ;
    end else if (wrAcc) begin
      if (paddr == `VPDMA_OFF_REQSZ) begin
        reqSize_q <= reqMerge[`VPDMA_REQSZ_W-1:0];
      end else if (paddr == `VPDMA_OFF_CH0TY) begin
        ch0TopLuma_q <= ch0Merge;
      end else if (paddr == `VPDMA_OFF_CH1TY) begin
        // stored, used only in Y/C mux
        ch1TopLuma_q <= ch1Merge;
      end else if (paddr == `VPDMA_OFF_CTRL) begin
        ctrl_q <= ctrlMerge[`VPDMA_CTRL_W-1:0];
      end else if (paddr == `VPDMA_OFF_HSZ) begin
        hsize0_q <= hszMerge[`VPDMA_HSZ0];
        hsize1_q <= hszMerge[`VPDMA_HSZ1];
      end
    end
  end

  // Read decode; unmapped addresses read zero and flag an error
  always @* begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (paddr == `VPDMA_OFF_REQSZ) begin
      prdata = {23'h000000, reqSize_q};
    end else if (paddr == `VPDMA_OFF_CH0TY) begin
      prdata = ch0TopLuma_q;
    end else if (paddr == `VPDMA_OFF_CH1TY) begin
      prdata = ch1TopLuma_q;
    end else if (paddr == `VPDMA_OFF_CTRL) begin
      prdata = {25'h0000000, ctrl_q};
    end else if (paddr == `VPDMA_OFF_HSZ) begin
      prdata = hszOld;
    end else if (paddr == `VPDMA_OFF_STAT) begin
      // Live byte counts and request levels
      prdata = {ch1DmaReq, ch0DmaReq, 4'h0, ch1Bytes, 6'h00, ch0Bytes};
    end else begin
      pslverr = psel & penable;
    end
    if (!rdAcc) begin
      prdata = 32'h00000000;
    end
  end

  // ==========================================
  // Timing pin synchronisers
  // Three stages; a level counts only once stages two and three agree
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] sync3_q;
  reg [3:0] level_q;
  wire [3:0] pins = {ch1VbiPin, ch1ActivePin, ch0VbiPin, ch0ActivePin};
  wire [3:0] agreeHi = sync2_q & sync3_q;
  wire [3:0] agreeLo = ~sync2_q & ~sync3_q;
  wire [3:0] rise = agreeHi & ~level_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      level_q <= 4'h0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // Hold the accepted level while the stages disagree
      level_q <= (level_q | agreeHi) & ~agreeLo;
    end
  end

  // ==========================================
  // Channel 0
  // channel 0 buffer and request
  vpdma_chan #(
    .DW(DW),
    .AW(AW)
  ) u_chan0 (
    .clk(clk),
    .arst_n(arst_n),
    .capMode(cap0),
    .reqSize(reqSize_q),
    .vidStb(ch0VidStb),
    .vidWrData(ch0VidWrData),
    .vidReady(ch0VidReady),
    .memStb(ch0MemStb),
    .memWrData(ch0MemWrData),
    .memReady(ch0MemReady),
    .dmaAck(ch0DmaAck),
    .dmaReq(ch0DmaReq),
    .rdData_q(ch0RdData),
    .bytes_q(ch0Bytes)
  );

  // channel 0 always uses its start address
  vpdma_addr u_addr0 (
    .clk(clk),
    .arst_n(arst_n),
    .enable(1'b1),
    .mode(ctrl_q[`VPDMA_CTRL_MODE0]),
    .base(ch0TopLuma_q),
    .hsize(hsize0_q),
    .reqSize(reqSize_q),
    .actStart(rise[0]),
    .vbiStart(rise[1]),
    .dmaAck(ch0DmaAck & ch0DmaReq),
    .addr_q(ch0DmaAddr)
  );

  // ==========================================
  // Channel 1
  // separate bookkeeping
  vpdma_chan #(
    .DW(DW),
    .AW(AW)
  ) u_chan1 (
    .clk(clk),
    .arst_n(arst_n),
    .capMode(cap1),
    .reqSize(reqSize_q),
    .vidStb(ch1VidStb),
    .vidWrData(ch1VidWrData),
    .vidReady(ch1VidReady),
    .memStb(ch1MemStb),
    .memWrData(ch1MemWrData),
    .memReady(ch1MemReady),
    .dmaAck(ch1DmaAck),
    .dmaReq(ch1DmaReq),
    .rdData_q(ch1RdData),
    .bytes_q(ch1Bytes)
  );

  // address held at zero unless Y/C mux
  vpdma_addr u_addr1 (
    .clk(clk),
    .arst_n(arst_n),
    .enable(ycMux),
    .mode(ctrl_q[`VPDMA_CTRL_MODE1]),
    .base(ch1TopLuma_q),
    .hsize(hsize1_q),
    .reqSize(reqSize_q),
    .actStart(rise[2]),
    .vbiStart(rise[3]),
    .dmaAck(ch1DmaAck & ch1DmaReq),
    .addr_q(ch1DmaAddr)
  );

  // ==========================================
  // Read data routing
  // One read register per channel serves whichever side drains it
  assign ch0VidRdData = ch0RdData;
  assign ch0MemRdData = ch0RdData;
  assign ch1VidRdData = ch1RdData;
  assign ch1MemRdData = ch1RdData;

endmodule // vpdma_top

/* File: dv/vpdma_top_sva.sv */
// Checker for the video port DMA block, bound to the top ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ns
module vpdma_top_sva #(
  parameter DW = 64
) (
  // Clock, reset and APB
  input wire clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Channel strobes and requests
  input wire ch0VidStb,
  input wire ch0MemStb,
  input wire [DW-1:0] ch0MemRdData,
  input wire ch0DmaReq,
  input wire ch0DmaAck,
  input wire [31:0] ch0DmaAddr,
  input wire ch1VidStb,
  input wire ch1DmaReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Access phase helpers
  wire acc = psel && penable;
  wire wrAcc = acc && pwrite;
  property p_ready; acc |-> pready; endproperty
  property p_err; pslverr |-> acc && (paddr > 12'h014); endproperty
  property p_idle; !(acc && !pwrite) |-> prdata == 32'h0; endproperty
  property p_rsv; acc && !pwrite && paddr == 12'h000 |-> prdata[31:9] == 23'h0; endproperty
  property p_rise0; $rose(ch0DmaReq) |-> $past(ch0VidStb || wrAcc); endproperty
  property p_fall0; $fell(ch0DmaReq) |-> $past(ch0DmaAck || wrAcc); endproperty
  property p_adv0; ch0DmaAck && ch0DmaReq |=> ch0DmaAddr != $past(ch0DmaAddr); endproperty
  property p_hold0; !$past(ch0MemStb) && !$past(ch0VidStb) |-> $stable(ch0MemRdData); endproperty
  property p_rise1; $rose(ch1DmaReq) |-> $past(ch1VidStb || wrAcc); endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err: assert property (p_err) else $error("pslverr on mapped access");
  a_idle: assert property (p_idle) else $error("prdata not zero when idle");
  a_rsv: assert property (p_rsv) else $error("reserved size bits set");
  a_rise0: assert property (p_rise0) else $error("ch0 request without cause");
  a_fall0: assert property (p_fall0) else $error("ch0 request dropped early");
  a_adv0: assert property (p_adv0) else $error("ch0 address not advanced");
  a_hold0: assert property (p_hold0) else $error("ch0 buffer data moved");
  a_rise1: assert property (p_rise1) else $error("ch1 request without cause");
  // Main scenarios reached
  c_ack0: cover property (ch0DmaAck && ch0DmaReq);
  c_req1: cover property ($rose(ch1DmaReq));
  c_err: cover property (acc && pslverr);
endmodule // vpdma_top_sva

/* File: dv/vpdma_sdram_model.sv */
// SDRAM path model: drains or fills one channel buffer per request.
// Assumes strobes on clk; serves requests only while enabled.
`timescale 1ns/1ns
module vpdma_sdram_model (
  // Clock and reset
  input logic clk,
  input logic arst_n,
  // Bench control
  input logic en,
  input logic prime,
  input logic [5:0] words,
  // Buffer side
  input logic dmaReq,
  input logic memReady,
  input logic [63:0] memRdData,
  output logic memStb,
  output logic [63:0] memWrData,
  output logic dmaAck,
  output logic [63:0] lastRd
);
  logic [5:0] left;
  logic ackPend, stbD;
  // ==========================================
  // requests served whole
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left <= 6'h0;
      ackPend <= 1'b0;
      stbD <= 1'b0;
      memStb <= 1'b0;
      dmaAck <= 1'b0;
      memWrData <= 64'h0;
      lastRd <= 64'h0;
    end else begin
      memStb <= 1'b0;
      dmaAck <= 1'b0;
      stbD <= memStb;
      // Idle data toggles so stale words never look valid
      memWrData <= ~memWrData;
      if (stbD) lastRd <= memRdData;
      if (left != 6'h0) begin
        if (memReady) begin
          memStb <= 1'b1;
          memWrData <= {32'hF00D0000, 26'h0, left};
          left <= left - 6'h1;
        end
      end else if (ackPend) begin
        dmaAck <= 1'b1;
        ackPend <= 1'b0;
      end else if (prime) begin
        left <= words;
      end else if (en && dmaReq && !dmaAck) begin
        left <= words;
        ackPend <= 1'b1;
      end
    end
  end
endmodule // vpdma_sdram_model

/* File: dv/vpdma_top_tb.sv */
// Self-checking bench for the two-channel video port DMA block.
// Assumes an APB master on clk and one SDRAM model per channel.
`timescale 1ns/1ns
`include "vpdma_defs.vh"
module vpdma_top_tb;
  localparam int DW = 64;
  // ==========================================
  // Signals
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rde, en0, en1, prime1;
  logic ch0VidStb, ch1VidStb, ch0MemStb, ch1MemStb, ch0MemReady, ch1MemReady;
  logic ch0VidReady, ch1VidReady, ch0DmaReq, ch1DmaReq, ch0DmaAck, ch1DmaAck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, sz, ch0DmaAddr, ch1DmaAddr;
  logic [3:0] pstrb, pins;
  logic [5:0] words;
  logic [DW-1:0] vidData, ch0MemWrData, ch1MemWrData, ch0MemRdData, ch1MemRdData;
  logic [DW-1:0] ch1VidRdData, last0;
  int errorCnt, totalChecks, cyc;
  vpdma_top #(.DW(DW), .AW(6)) dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch0ActivePin(pins[0]),
    .ch0VbiPin(pins[1]), .ch1ActivePin(pins[2]), .ch1VbiPin(pins[3]),
    .ch0VidStb(ch0VidStb), .ch0VidWrData(vidData), .ch0VidRdData(),
    .ch0VidReady(ch0VidReady), .ch0MemStb(ch0MemStb), .ch0MemWrData(ch0MemWrData),
    .ch0MemRdData(ch0MemRdData), .ch0MemReady(ch0MemReady), .ch0DmaReq(ch0DmaReq),
    .ch0DmaAck(ch0DmaAck), .ch0DmaAddr(ch0DmaAddr), .ch1VidStb(ch1VidStb),
    .ch1VidWrData(vidData), .ch1VidRdData(ch1VidRdData), .ch1VidReady(ch1VidReady),
    .ch1MemStb(ch1MemStb), .ch1MemWrData(ch1MemWrData), .ch1MemRdData(ch1MemRdData),
    .ch1MemReady(ch1MemReady), .ch1DmaReq(ch1DmaReq), .ch1DmaAck(ch1DmaAck),
    .ch1DmaAddr(ch1DmaAddr));
  vpdma_sdram_model p0 (.clk(clk), .arst_n(arst_n), .en(en0), .prime(1'b0), .words(words),
    .dmaReq(ch0DmaReq), .memReady(ch0MemReady), .memRdData(ch0MemRdData),
    .memStb(ch0MemStb), .memWrData(ch0MemWrData), .dmaAck(ch0DmaAck), .lastRd(last0));
  vpdma_sdram_model p1 (.clk(clk), .arst_n(arst_n), .en(en1), .prime(prime1), .words(words),
    .dmaReq(ch1DmaReq), .memReady(ch1MemReady), .memRdData(ch1MemRdData),
    .memStb(ch1MemStb), .memWrData(ch1MemWrData), .dmaAck(ch1DmaAck), .lastRd());
  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      finalReport();
    end
  end
  // ==========================================
  // Tasks
  task automatic finalReport();
    if (errorCnt == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; the global guard bounds the wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rdv);
    chk("pslverr", a > 12'h014, rde);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    pins <= m;
    repeat (4) @(posedge clk);
    pins <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic push(input logic ch, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (ch) ch1VidStb <= 1'b1;
      else ch0VidStb <= 1'b1;
      vidData <= vidData + 64'h1;
    end
    @(posedge clk);
    ch0VidStb <= 1'b0;
    ch1VidStb <= 1'b0;
    @(negedge clk);
  endtask
  task automatic waitIdle();
    en0 <= 1'b1;
    en1 <= 1'b1;
    @(posedge clk);
    while (ch0DmaReq !== 1'b0 || ch1DmaReq !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
    en0 <= 1'b0;
    en1 <= 1'b0;
    @(negedge clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, pins, en0, en1, prime1} = '0;
    {ch0VidStb, ch1VidStb, errorCnt, totalChecks, cyc} = '0;
    pstrb = 4'hF;
    words = 6'h04;
    vidData = 64'hA5A5000000000000;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(`VPDMA_OFF_REQSZ, 32'h020);
    rd(`VPDMA_OFF_CH0TY, 32'h0);
    rd(`VPDMA_OFF_CH1TY, 32'h0);
    rd(`VPDMA_OFF_HSZ, 32'h00100010);
    rd(12'h018, 32'h0);
    chk("ch0VidReady", 1'b0, ch0VidReady);
    chk("ch0MemReady", 1'b1, ch0MemReady);
    apb(1'b1, `VPDMA_OFF_REQSZ, 32'hFFFFFFFF);
    rd(`VPDMA_OFF_REQSZ, 32'h1FF);
    apb(1'b1, `VPDMA_OFF_CTRL, 32'h1);
    // Let the control write settle before looking at the ready levels
    @(negedge clk);
    chk("ch0VidReady", 1'b1, ch0VidReady);
    chk("ch0MemReady", 1'b0, ch0MemReady);
    apb(1'b1, `VPDMA_OFF_CH0TY, 32'h1000);
    for (int k = 0; k < 3; k++) begin
      sz = 32'h20 << k;
      words <= sz[8:3];
      apb(1'b1, `VPDMA_OFF_REQSZ, sz);
      pulse(4'h1);
      chk("ch0DmaAddr", 32'h1000, ch0DmaAddr);
      push(1'b0, sz / 8 - 1);
      chk("ch0DmaReq", 1'b0, ch0DmaReq);
      push(1'b0, 1);
      chk("ch0DmaReq", 1'b1, ch0DmaReq);
      chk("ch1DmaReq", 1'b0, ch1DmaReq);
      rd(`VPDMA_OFF_STAT, 32'h40000000 | sz);
      waitIdle();
      chk("ch0DmaAddr", 32'h1000 + sz, ch0DmaAddr);
      chk("drained word", vidData, last0);
    end
    apb(1'b1, `VPDMA_OFF_CTRL, 32'h5);
    for (int k = 0; k < 5; k++) begin
      sz = 32'h10 << k;
      apb(1'b1, `VPDMA_OFF_HSZ, 32'h00100000 | sz);
      apb(1'b1, `VPDMA_OFF_CH0TY, 32'h8000 | sz);
      pulse(4'h1);
      chk("ch0DmaAddr", 32'h8000 | sz, ch0DmaAddr);
    end
    apb(1'b1, `VPDMA_OFF_CTRL, 32'h1);
    apb(1'b1, `VPDMA_OFF_CH0TY, 32'h5000);
    pulse(4'h2);
    chk("ch0DmaAddr", 32'h5000, ch0DmaAddr);
    apb(1'b1, `VPDMA_OFF_CTRL, 32'h0);
    apb(1'b1, `VPDMA_OFF_CH1TY, 32'h3000);
    rd(`VPDMA_OFF_CH1TY, 32'h3000);
    pulse(4'h4);
    chk("ch1DmaAddr", 32'h0, ch1DmaAddr);
    apb(1'b1, `VPDMA_OFF_CTRL, 32'h40);
    pulse(4'h4);
    chk("ch1DmaAddr", 32'h3000, ch1DmaAddr);
    apb(1'b1, `VPDMA_OFF_REQSZ, 32'h20);
    words <= 6'h04;
    @(posedge clk);
    prime1 <= 1'b1;
    @(posedge clk);
    prime1 <= 1'b0;
    repeat (10) @(posedge clk);
    push(1'b1, 4);
    chk("ch1VidRdData", 64'hF00D000000000001, ch1VidRdData);
    chk("ch1MemRdData", 64'hF00D000000000001, ch1MemRdData);
    chk("ch1VidReady", 1'b0, ch1VidReady);
    chk("ch1DmaReq", 1'b1, ch1DmaReq);
    chk("ch0DmaReq", 1'b0, ch0DmaReq);
    rd(`VPDMA_OFF_STAT, 32'h80200000);
    waitIdle();
    chk("ch1DmaAddr", 32'h3020, ch1DmaAddr);
    finalReport();
  end
endmodule // vpdma_top_tb
bind vpdma_top vpdma_top_sva #(.DW(DW)) u_sva (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ch0VidStb(ch0VidStb), .ch0MemStb(ch0MemStb),
  .ch0MemRdData(ch0MemRdData), .ch0DmaReq(ch0DmaReq), .ch0DmaAck(ch0DmaAck),
  .ch0DmaAddr(ch0DmaAddr), .ch1VidStb(ch1VidStb), .ch1DmaReq(ch1DmaReq));
